//--- pkg/swd_pkg.sv
// Constants, types and register map of the system watchdog
package swd_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
   localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_INT_STAT = 8'h0C;
   localparam logic [7:0] OFS_INT_CLR = 8'h10;
   localparam logic [7:0] OFS_INT_EN = 8'h14;
   // Input clock dividers
   localparam int unsigned DIV_FAST = 256;
   localparam int unsigned DIV_SLOW = 16384;
   // Fixed and reset counter values
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   localparam logic [15:0] TIMEOUT_RELOAD = 16'hFFFC;
   localparam logic [15:0] PREWARN_RELOAD = 16'hFFF0;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // Password fields
   localparam logic [5:0] PW_RST = 6'h00;
   localparam logic [7:0] FIRST_GUARD = 8'h00;
   localparam logic [7:0] SECOND_GUARD = 8'hA5;
   localparam logic ENDINIT_RST = 1'b1;
   // Config register fields
   localparam int unsigned CFG_DIS_BIT = 0;
   localparam int unsigned CFG_FAST_BIT = 1;
   localparam logic [1:0] CFG_RST = 2'b00;
   // Interrupt status bits
   localparam int unsigned INT_W = 4;
   localparam int unsigned INT_ACC = 0;
   localparam int unsigned INT_OVF = 1;
   localparam int unsigned INT_SVC = 2;
   localparam int unsigned INT_UNLK = 3;
   localparam logic [3:0] INT_RST = 4'h0;
   // Watchdog reset pulse timing
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned RST_PULSE_NS = 640;
   localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] PULSE_LAST = 8'(RST_PULSE_CYC - 1);
   localparam logic [7:0] PULSE_RST = 8'h00;

   // Operating modes, one-hot
   typedef enum logic [3:0] {
      ST_NORMAL = 4'b0001,
      ST_TIMEOUT = 4'b0010,
      ST_PREWARN = 4'b0100,
      ST_RESET = 4'b1000
   } swd_state_e;

   // Layout of the first control register
   typedef struct packed {
      logic [15:0] reload;
      logic [7:0] guard;
      logic [5:0] pw;
      logic lock;
      logic endinit;
   } swd_ctrl_word_s;
endpackage : swd_pkg

//--- rtl/swd_prescaler.sv
// Input clock divider for the watchdog counter
`timescale 1ns/1ps
`default_nettype none
module swd_prescaler #(
   parameter int unsigned DIV_FAST = swd_pkg::DIV_FAST,
   parameter int unsigned DIV_SLOW = swd_pkg::DIV_SLOW
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Control
   input wire logic clr,
   input wire logic fastSel,
   // Count enable pulse
   output logic tick
);
   localparam int unsigned CW = $clog2(DIV_SLOW);
   localparam logic [CW-1:0] LIM_FAST = CW'(DIV_FAST - 1);
   localparam logic [CW-1:0] LIM_SLOW = CW'(DIV_SLOW - 1);

   // Refuse dividers the counter cannot serve
   if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST) begin : g_chk
      $error("swd_prescaler: bad divider values");
   end

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   wire logic [CW-1:0] limit = fastSel ? LIM_FAST : LIM_SLOW;

   // One tick per divided period
   assign tick = (cnt_r >= limit);
   assign cnt_nxt = tick ? '0 : cnt_r + CW'(1);

   // Divider counter
   always_ff @(posedge clk_sys) begin
      if (sys_rst || clr) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : swd_prescaler
`default_nettype wire

//--- rtl/swd_access_check.sv
// Password and guard checks for the two-write access
`timescale 1ns/1ps
`default_nettype none
module swd_access_check (
   // Written word and current settings
   input wire swd_pkg::swd_ctrl_word_s word,
   input wire logic [5:0] pwCur,
   input wire logic [15:0] reloadCur,
   // Check results
   output logic firstOk,
   output logic secondOk
);
   // Fixed lock and guard fields plus user password and reload must match
   assign firstOk = word.lock && (word.guard == swd_pkg::FIRST_GUARD) && (word.pw == pwCur)
      && (word.reload == reloadCur);
   // Second write carries the fixed guard pattern and relocks
   assign secondOk = word.lock && (word.guard == swd_pkg::SECOND_GUARD);
endmodule : swd_access_check
`default_nettype wire

//--- rtl/swd_watchdog.sv
// System watchdog with end-of-init protect line, prewarning and double reset hold
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: When enabled, an unserviced watchdog causes a full system reset.
// R2: End-of-init bit drives protect line; writes need supervisor mode and bit zero.
// R3: Errors raise a non-maskable interrupt first, reset only after a further period.
// R4: 16-bit counter ticks at clock/256 or clock/16384; normal reload is software's.
// R5: Time-out and prewarning modes reload the counter with fixed values.
// R6: Each service is two writes; the time between them is limited.
// R7: Password mixes fixed and software fields, all checked on the first write.
// R8: Wrong password or wrong guard bits are access errors starting reset generation.
// R9: Counter overflow is an error that starts reset generation.
// R10: With timeout disabled, password checks and end-of-init monitoring still work.
// R11: Two watchdog resets without proper access hold reset until hardware reset.
// R12: A completed service reloads the counter and clears the earlier-reset record.
module swd_watchdog (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // CPU mode
   input wire logic supervisorMode,
   // System outputs
   output logic protectWrEn,
   output logic nmiReq,
   output logic sysResetReq,
   output logic irq
);
   // Address match
   function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
      isReg = (a == ofs);
   endfunction : isReg

   swd_pkg::swd_state_e state_r;
   swd_pkg::swd_state_e state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] reload_r;
   logic [5:0] pw_r;
   logic endinit_r;
   logic [1:0] cfg_r;
   logic rstSeen_r;
   logic holdRst_r;
   logic [7:0] pulse_r;
   logic [3:0] intStat_r;
   logic [3:0] intStat_nxt;
   logic [3:0] intEn_r;
   logic [31:0] rdata_nxt;
   logic tick;
   logic firstOk;
   logic secondOk;
   logic [16:0] toCnt_r;
   // Longest stay in time-out mode: clock cycles in the slow ticks from the fixed reload to overflow
   localparam logic [16:0] TO_MAX = 17'((swd_pkg::CNT_MAX - swd_pkg::TIMEOUT_RELOAD + 16'h0001) * swd_pkg::DIV_SLOW);

   // Decoded writes and state flags
   wire swd_pkg::swd_ctrl_word_s ctrlW = swd_pkg::swd_ctrl_word_s'(regWdata);
   wire logic wrFirst = regWr && isReg(regAddr, swd_pkg::OFS_CTRL_FIRST);
   wire logic wrCfg = regWr && isReg(regAddr, swd_pkg::OFS_CTRL_SECOND);
   wire logic wrIntClr = regWr && isReg(regAddr, swd_pkg::OFS_INT_CLR);
   wire logic wrIntEn = regWr && isReg(regAddr, swd_pkg::OFS_INT_EN);
   wire logic inNormal = (state_r == swd_pkg::ST_NORMAL);
   wire logic inTimeout = (state_r == swd_pkg::ST_TIMEOUT);
   wire logic inPrewarn = (state_r == swd_pkg::ST_PREWARN);
   wire logic inReset = (state_r == swd_pkg::ST_RESET);
   wire logic cfgDis = cfg_r[swd_pkg::CFG_DIS_BIT];

   // Divided count clock
   // A service does not clear the divider, so the first tick after it may come early
   swd_prescaler #(
      .DIV_FAST(swd_pkg::DIV_FAST),
      .DIV_SLOW(swd_pkg::DIV_SLOW)
   ) u_presc (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clr(inReset),
      .fastSel(cfg_r[swd_pkg::CFG_FAST_BIT]),
      .tick(tick)
   ); // [R4]

   // Password and guard checks
   // The first write repeats the reload value, which keeps stray writes from unlocking
   swd_access_check u_chk (
      .word(ctrlW),
      .pwCur(pw_r),
      .reloadCur(reload_r),
      .firstOk(firstOk),
      .secondOk(secondOk)
   ); // [R7]

   // Counter run and overflow; disable only stops normal mode
   wire logic countOn = (inNormal && !cfgDis) || inTimeout || inPrewarn; // [R1] [R10]
   wire logic ovf = tick && countOn && (cnt_r == swd_pkg::CNT_MAX);
   wire logic ovfErr = ovf && (inNormal || inTimeout); // [R9] [R6]
   // Access events; checks run whether or not timeout is disabled.
   // A write landing on the overflow edge came too late, so the error wins over it.
   wire logic unlock = wrFirst && inNormal && firstOk && !ovfErr; // [R6] [R7]
   wire logic svcDone = wrFirst && inTimeout && secondOk && !ovfErr; // [R6]
   wire logic accErr = wrFirst && ((inNormal && !firstOk) || (inTimeout && !secondOk)); // [R8] [R10]
   wire logic errStart = accErr || ovfErr; // [R3]
   wire logic rstStart = ovf && inPrewarn; // [R3] [R1]
   wire logic pulseDone = inReset && (pulse_r == swd_pkg::PULSE_LAST);
   wire logic wdtRstEnd = pulseDone && !holdRst_r; // [R11]
   // The end of a watchdog reset pulse re-initialises mode, counter, settings and interrupts as a hardware reset does
   wire logic softRst = sys_rst || wdtRstEnd;

   // Mode sequencing
   always_comb begin
      case (state_r)
         swd_pkg::ST_NORMAL: begin
            if (errStart) begin
               state_nxt = swd_pkg::ST_PREWARN; // [R3]
            end else if (unlock) begin
               state_nxt = swd_pkg::ST_TIMEOUT; // [R6]
            end else begin
               state_nxt = swd_pkg::ST_NORMAL;
            end
         end
         swd_pkg::ST_TIMEOUT: begin
            if (errStart) begin
               state_nxt = swd_pkg::ST_PREWARN; // [R8]
            end else if (svcDone) begin
               state_nxt = swd_pkg::ST_NORMAL;
            end else begin
               state_nxt = swd_pkg::ST_TIMEOUT;
            end
         end
         swd_pkg::ST_PREWARN: begin
            state_nxt = rstStart ? swd_pkg::ST_RESET : swd_pkg::ST_PREWARN; // [R3]
         end
         swd_pkg::ST_RESET: begin
            state_nxt = wdtRstEnd ? swd_pkg::ST_NORMAL : swd_pkg::ST_RESET; // [R11]
         end
         default: begin
            state_nxt = swd_pkg::ST_NORMAL;
         end
      endcase
   end

   // Counter reload and count
   // Service events and errors exclude each other, so the order below is safe
   always_comb begin
      if (unlock) begin
         cnt_nxt = swd_pkg::TIMEOUT_RELOAD; // [R5]
      end else if (svcDone) begin
         cnt_nxt = ctrlW.reload; // [R12] [R4]
      end else if (errStart && !inPrewarn) begin
         cnt_nxt = swd_pkg::PREWARN_RELOAD; // [R5]
      end else if (inReset) begin
         cnt_nxt = swd_pkg::CNT_RST;
      end else if (tick && countOn) begin
         cnt_nxt = cnt_r + 16'h0001; // [R4]
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   // Sticky interrupt status, set beats clear
   assign intStat_nxt = (intStat_r & ~(wrIntClr ? regWdata[3:0] : 4'h0))
      | {unlock, svcDone, ovfErr, accErr};

   // Read data selection
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (regRd) begin
         if (isReg(regAddr, swd_pkg::OFS_CTRL_FIRST)) begin
            rdata_nxt = {reload_r, 8'h00, pw_r, !inTimeout, endinit_r};
         end else if (isReg(regAddr, swd_pkg::OFS_CTRL_SECOND)) begin
            rdata_nxt = {30'h0000_0000, cfg_r};
         end else if (isReg(regAddr, swd_pkg::OFS_STATUS)) begin
            rdata_nxt = {cnt_r, 9'h000, rstSeen_r, cfg_r, state_r};
         end else if (isReg(regAddr, swd_pkg::OFS_INT_STAT)) begin
            rdata_nxt = {28'h000_0000, intStat_r};
         end else if (isReg(regAddr, swd_pkg::OFS_INT_EN)) begin
            rdata_nxt = {28'h000_0000, intEn_r};
         end
      end
   end

   // Mode and counter, re-initialised after a watchdog reset
   always_ff @(posedge clk_sys) begin
      if (softRst) begin
         state_r <= swd_pkg::ST_NORMAL;
         cnt_r <= swd_pkg::CNT_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Software settings, written by the second write of a service
   always_ff @(posedge clk_sys) begin
      if (softRst) begin
         reload_r <= swd_pkg::RELOAD_RST;
         pw_r <= swd_pkg::PW_RST;
         endinit_r <= swd_pkg::ENDINIT_RST;
      end else if (svcDone) begin
         reload_r <= ctrlW.reload; // [R4]
         pw_r <= ctrlW.pw; // [R7]
         endinit_r <= ctrlW.endinit; // [R2]
      end
   end

   // Config needs the protect line open
   // A user-mode task can neither disable the watchdog nor slow it down
   always_ff @(posedge clk_sys) begin
      if (softRst) begin
         cfg_r <= swd_pkg::CFG_RST;
      end else if (wrCfg && protectWrEn) begin
         cfg_r <= regWdata[1:0]; // [R2]
      end
   end

   // Interrupt registers
   // Set and clear in one cycle: the set wins so no event is lost
   always_ff @(posedge clk_sys) begin
      if (softRst) begin
         intStat_r <= swd_pkg::INT_RST;
         intEn_r <= swd_pkg::INT_RST;
      end else begin
         intStat_r <= intStat_nxt;
         intEn_r <= wrIntEn ? regWdata[3:0] : intEn_r;
      end
   end

   // Earlier-reset record survives watchdog resets
   // Only a hardware reset clears the hold, so a system that keeps failing
   // its start-up stays quiet instead of resetting again and again
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rstSeen_r <= 1'b0;
         holdRst_r <= 1'b0;
      end else begin
         if (rstStart) begin
            rstSeen_r <= 1'b1;
         end else if (svcDone) begin
            rstSeen_r <= 1'b0; // [R12]
         end
         if (rstStart && rstSeen_r) begin
            holdRst_r <= 1'b1; // [R11]
         end
      end
   end

   // Reset pulse length and read data
   // The pulse counter wraps in a held reset, which is harmless
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pulse_r <= swd_pkg::PULSE_RST;
         regRdata <= 32'h0000_0000;
      end else begin
         pulse_r <= (inReset && !pulseDone) ? pulse_r + 8'h01 : swd_pkg::PULSE_RST;
         regRdata <= rdata_nxt;
      end
   end

   // System outputs
   assign protectWrEn = supervisorMode && !endinit_r; // [R2]
   assign nmiReq = inPrewarn; // [R3]
   assign sysResetReq = inReset; // [R1]
   assign irq = |(intStat_r & intEn_r);

   // Cycles spent in time-out mode, bounded by a check below
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !inTimeout) begin
         toCnt_r <= 17'h00000;
      end else begin
         toCnt_r <= toCnt_r + 17'h00001; // [R6]
      end
   end

   // Checks run on the system clock and rest while hardware reset is high
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_protect_gate: assert property ((endinit_r || !supervisorMode) |-> !protectWrEn) // [R2]
      else $error("protect line open while end-of-init set or user mode");
   a_svc_endinit: assert property (svcDone |=> endinit_r == $past(ctrlW.endinit)) // [R2]
      else $error("end-of-init bit not taken from service write");
   a_err_nmi_first: assert property (errStart |=> nmiReq && !sysResetReq) // [R3]
      else $error("error did not raise prewarning first");
   a_reset_after_nmi: assert property ($rose(sysResetReq) |-> $past(nmiReq)) // [R3]
      else $error("reset without prior prewarning");
   a_ovf_error: assert property (ovfErr |=> inPrewarn && cnt_r == swd_pkg::PREWARN_RELOAD) // [R9]
      else $error("overflow did not start prewarning");
   a_acc_error: assert property ((wrFirst && inTimeout && !secondOk) |=> nmiReq) // [R8]
      else $error("bad guard bits not treated as error");
   a_unlock_reload: assert property (unlock |=> inTimeout && cnt_r == swd_pkg::TIMEOUT_RELOAD) // [R5]
      else $error("unlock did not load fixed time-out value");
   a_svc_reload: assert property (svcDone |=> cnt_r == $past(ctrlW.reload) && !rstSeen_r) // [R12]
      else $error("service did not reload counter or clear record");
   a_disabled_check: assert property ((cfgDis && wrFirst && inNormal && !firstOk) |=> nmiReq) // [R10]
      else $error("password check lost while timeout disabled");
   a_disabled_hold: assert property ((cfgDis && inNormal && !wrFirst) |=> $stable(cnt_r)) // [R10]
      else $error("counter ran in normal mode while disabled");
   a_double_hold: assert property ((rstStart && rstSeen_r) |=> sysResetReq[*8]) // [R11]
      else $error("double reset did not hold reset");
   a_reset_pulse: assert property ($rose(sysResetReq) |-> sysResetReq[*8]) // [R1]
      else $error("watchdog reset pulse too short");
   a_count_step: assert property ((tick && inTimeout && !wrFirst && cnt_r != swd_pkg::CNT_MAX)
      |=> cnt_r == $past(cnt_r) + 16'h0001) // [R4]
      else $error("counter did not step on tick");

   // Access time limit and error priority
   a_access_window: assert property (inTimeout |-> toCnt_r < TO_MAX) // [R6]
      else $error("time-out mode outlasted the access limit");
   a_late_write: assert property ((wrFirst && ovfErr) |=> inPrewarn) // [R6]
      else $error("write on overflow edge hid the error");
   a_acc_reload: assert property (accErr |=> cnt_r == swd_pkg::PREWARN_RELOAD) // [R5]
      else $error("access error did not load prewarning value");
   a_busy_ignored: assert property ((wrFirst && inPrewarn) |=> $stable(pw_r) && $stable(reload_r)) // [R7]
      else $error("control write taken during prewarning");

   // Event flags
   a_acc_flag: assert property (accErr |=> intStat_r[swd_pkg::INT_ACC]) // [R8]
      else $error("access error flag not set");
   a_ovf_flag: assert property (ovfErr |=> intStat_r[swd_pkg::INT_OVF]) // [R9]
      else $error("overflow flag not set");
   a_svc_flag: assert property (svcDone |=> intStat_r[swd_pkg::INT_SVC]) // [R12]
      else $error("service flag not set");
   a_unlock_flag: assert property (unlock |=> intStat_r[swd_pkg::INT_UNLK]) // [R7]
      else $error("unlock flag not set");

   // Protection, prewarning and reset sequencing
   a_endinit_keep: assert property ((!svcDone && !softRst) |=> $stable(endinit_r)) // [R2]
      else $error("end-of-init changed without service");
   a_cfg_locked: assert property ((wrCfg && !protectWrEn && !softRst) |=> $stable(cfg_r)) // [R2]
      else $error("config written while protected");
   a_no_cancel: assert property (nmiReq |=> nmiReq || sysResetReq) // [R3]
      else $error("prewarning left without reset");
   a_prewarn_step: assert property ((tick && inPrewarn && cnt_r != swd_pkg::CNT_MAX)
      |=> cnt_r == $past(cnt_r) + 16'h0001) // [R4]
      else $error("prewarning counter did not step");
   a_record_set: assert property (rstStart |=> rstSeen_r && sysResetReq) // [R11]
      else $error("watchdog reset not recorded");
   a_hold_stays: assert property (holdRst_r |-> sysResetReq) // [R11]
      else $error("held reset released");
   a_reset_end: assert property (wdtRstEnd |=> inNormal && !sysResetReq) // [R1]
      else $error("block not re-initialised after reset pulse");
endmodule : swd_watchdog
`default_nettype wire

//--- verif/swd_cpu_model.sv
// CPU software model that services the watchdog over the register port
`timescale 1ns/1ps
`default_nettype none
module swd_cpu_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [7:0] regAddr,
   output logic [31:0] regWdata,
   output logic regWr,
   output logic regRd,
   input wire logic [31:0] regRdata,
   // CPU mode
   output logic supervisorMode
);
   // Idle bus from time zero
   initial begin
      regAddr = 8'h00;
      regWdata = 32'h00000000;
      regWr = 1'b0;
      regRd = 1'b0;
      supervisorMode = 1'b1;
   end
   // One-cycle write; released lines show the inverse so stale data never passes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask : wr
   // One-cycle read; data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      regAddr <= ~a;
      @(negedge clk_sys);
      d = regRdata;
   endtask : rd
   // Service is always a pair of writes to the first control register
   task automatic service(input logic [31:0] first, input logic [31:0] second);
      wr(swd_pkg::OFS_CTRL_FIRST, first);
      wr(swd_pkg::OFS_CTRL_FIRST, second);
   endtask : service
   // Change of CPU mode just after an edge
   task automatic sup(input logic v);
      @(posedge clk_sys);
      supervisorMode <= v;
   endtask : sup
endmodule : swd_cpu_model
`default_nettype wire

//--- verif/swd_watchdog_test.sv
// Self-checking testbench of the system watchdog
`timescale 1ns/1ps
`default_nettype none
module swd_watchdog_test;
   // Clock, reset and port nets
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   wire logic [7:0] regAddr;
   wire logic [31:0] regWdata;
   wire logic regWr;
   wire logic regRd;
   wire logic [31:0] regRdata;
   wire logic supervisorMode;
   wire logic protectWrEn;
   wire logic nmiReq;
   wire logic sysResetReq;
   wire logic irq;
   int error_cnt = 0;
   int cmp_count = 0;
   logic [31:0] v;
   logic [31:0] w;
   // 25 MHz clock
   always #20 clk_sys = ~clk_sys;
   swd_watchdog dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .supervisorMode(supervisorMode),
      .protectWrEn(protectWrEn), .nmiReq(nmiReq), .sysResetReq(sysResetReq), .irq(irq));
   swd_cpu_model cpu (.clk_sys(clk_sys), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .supervisorMode(supervisorMode));
   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk
   // Control word builder
   function automatic logic [31:0] cw(logic [15:0] r, logic [7:0] g, logic [5:0] p, logic l, logic e);
      swd_pkg::swd_ctrl_word_s s;
      s.reload = r;
      s.guard = g;
      s.pw = p;
      s.lock = l;
      s.endinit = e;
      return s;
   endfunction : cw
   // Bounded wait for nmiReq (sel 0) or sysResetReq (sel 1)
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      while (((sel == 0) ? nmiReq : sysResetReq) !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > lim) begin
            error_cnt++;
            $display("wrong value at %0t: wait ran out", $time);
            report_and_stop();
         end
      end
   endtask : wait_hi
   // Reset state and unmapped read
   task automatic t_reset();
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk(v, 32'h00000001, "status after reset");
      cpu.rd(swd_pkg::OFS_INT_STAT, v);
      chk(v, 32'h00000000, "int status after reset");
      cpu.rd(8'h40, v);
      chk(v, 32'h00000000, "unmapped read");
      chk(32'(protectWrEn), 32'h00000000, "protect with endinit set");
   endtask : t_reset
   // Two-write service, endinit release and protected config
   task automatic t_service();
      cpu.wr(swd_pkg::OFS_CTRL_FIRST, cw(16'h0000, 8'h00, 6'h00, 1'b1, 1'b1));
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk({v[31:16], 12'h000, v[3:0]}, 32'hFFFC0002, "time-out after first write");
      cpu.wr(swd_pkg::OFS_CTRL_FIRST, cw(16'hFFF0, 8'hA5, 6'h15, 1'b1, 1'b0));
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk({v[31:16], 11'h000, v[6], v[3:0]}, 32'hFFF00001, "normal after service");
      chk(32'(protectWrEn), 32'h00000001, "protect open");
      cpu.sup(1'b0);
      @(negedge clk_sys);
      chk(32'(protectWrEn), 32'h00000000, "protect without supervisor");
      cpu.wr(swd_pkg::OFS_CTRL_SECOND, 32'h00000002);
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk(32'(v[5:4]), 32'h00000000, "config write refused");
      cpu.sup(1'b1);
      cpu.wr(swd_pkg::OFS_CTRL_SECOND, 32'h00000002);
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk(32'(v[5:4]), 32'h00000002, "fast divider selected");
   endtask : t_service
   // Counter advances once per 256 clocks in fast mode
   task automatic t_tick();
      cpu.rd(swd_pkg::OFS_STATUS, v);
      repeat (254) @(posedge clk_sys);
      cpu.rd(swd_pkg::OFS_STATUS, w);
      chk(32'(w[31:16] - v[31:16]), 32'h00000001, "one tick per 256 clocks");
   endtask : t_tick
   // Unserviced counter overflows, prewarns, then resets the system
   task automatic t_overflow();
      int n;
      wait_hi(0, 5000);
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk({v[31:16], 12'h000, v[3:0]}, 32'hFFF00004, "prewarning entered");
      cpu.rd(swd_pkg::OFS_INT_STAT, v);
      chk(32'(v[swd_pkg::INT_OVF]), 32'h00000001, "overflow flag");
      chk(32'(sysResetReq), 32'h00000000, "no reset during prewarning");
      wait_hi(1, 4500);
      chk(32'(nmiReq), 32'h00000000, "nmi drops at reset");
      n = 0;
      while (sysResetReq === 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      chk(n, 32'(swd_pkg::RST_PULSE_CYC), "reset pulse length");
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk({25'h0000000, v[6:0]}, 32'h00000041, "re-init and earlier-reset record");
   endtask : t_overflow
   // Wrong password, interrupt raise, mask and clear
   task automatic t_access();
      cpu.wr(swd_pkg::OFS_INT_EN, 32'h00000001);
      cpu.wr(swd_pkg::OFS_CTRL_FIRST, cw(16'h0000, 8'h00, 6'h2A, 1'b1, 1'b1));
      @(negedge clk_sys);
      chk(32'(nmiReq), 32'h00000001, "nmi after bad password");
      chk(32'(irq), 32'h00000001, "access interrupt");
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk({v[31:16], 12'h000, v[3:0]}, 32'hFFF00004, "prewarning after error");
      cpu.wr(swd_pkg::OFS_INT_EN, 32'h00000000);
      @(negedge clk_sys);
      chk(32'(irq), 32'h00000000, "masked interrupt");
      cpu.wr(swd_pkg::OFS_INT_EN, 32'h00000001);
      cpu.wr(swd_pkg::OFS_INT_CLR, 32'h00000001);
      @(negedge clk_sys);
      chk(32'(irq), 32'h00000000, "cleared interrupt");
      cpu.rd(swd_pkg::OFS_INT_CLR, v);
      chk(v, 32'h00000000, "clear register reads zero");
   endtask : t_access
   // Mid-run reset; disabled timeout holds the count, access time limit still works
   task automatic t_disabled();
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      cpu.service(cw(16'h0000, 8'h00, 6'h00, 1'b1, 1'b1), cw(16'hFF00, 8'hA5, 6'h00, 1'b1, 1'b0));
      cpu.wr(swd_pkg::OFS_CTRL_SECOND, 32'h00000003);
      cpu.rd(swd_pkg::OFS_STATUS, v);
      chk(v, 32'hFF000031, "disabled fast mode after service");
      repeat (300) @(posedge clk_sys);
      cpu.rd(swd_pkg::OFS_STATUS, w);
      chk(w, 32'hFF000031, "count held while disabled");
      cpu.wr(swd_pkg::OFS_CTRL_FIRST, cw(16'hFF00, 8'h00, 6'h00, 1'b1, 1'b0));
      @(negedge clk_sys);
      chk(32'(nmiReq), 32'h00000000, "no error on good first write");
      wait_hi(0, 1100);
      chk(32'(nmiReq), 32'h00000001, "lone first write timed out");
   endtask : t_disabled
   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_service();
      t_tick();
      t_overflow();
      t_access();
      t_disabled();
      report_and_stop();
   end
endmodule : swd_watchdog_test
`default_nettype wire
